// [hdl/sarseq_pkg.sv]
package sarseq_pkg;
	// ==========================================
	// Register indices (byte address is four times the index).
	localparam logic [7:0] IDX_CONTROL = 8'h1f;
	localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'h1e;
	localparam logic [7:0] IDX_RESULT_LOW = 8'h9e;
	localparam logic [7:0] IDX_PORT_DATA = 8'h05;
	localparam logic [7:0] IDX_PIN_DIR = 8'h85;
	localparam logic [7:0] IDX_ANALOG_MASK = 8'ha0;
	localparam logic [7:0] IDX_STATUS = 8'ha1;
	// ==========================================
	// Field positions and reset values.
	localparam int CTL_POWER = 0;
	localparam int CTL_RESV = 1;
	localparam int CTL_RUN = 2;
	localparam int CTL_CHS_LO = 3;
	localparam int CTL_CLK_LO = 6;
	localparam int CFG_JUSTIFY = 7;
	localparam int STAT_DONE = 0;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] ANALOG_CFG_RST = 8'h00;
	localparam logic [7:0] PIN_DIR_RST = 8'hff;
	localparam logic [7:0] ANALOG_MASK_RST = 8'hff;
	localparam logic [7:0] CFG_WMASK = 8'h8f;
	// ==========================================
	// Clock source codes and timing counts.
	localparam logic [1:0] CLK_DIV2 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV32 = 2'h2;
	localparam logic [1:0] CLK_RC = 2'h3;
	localparam logic [4:0] DIV2_LAST = 5'h01;
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1f;
	localparam logic [2:0] TCY_CLKS = 3'h4;
	localparam logic [3:0] RESULT_MSB = 4'h9;
	localparam logic [9:0] SAR_FIRST = 10'h200;
	localparam logic [1:0] POST_TADS = 2'h2;
	localparam logic [3:0] TOTAL_TADS = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_SETUP,
		ST_BITS,
		ST_POST
	} sarseq_state_type;
endpackage

// [hdl/sarseq_top.sv]
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Clock select 00/01/10 give core clock /2, /8, /32; 11 picks RC clock.
// - Writing one to run while powered starts a conversion; bit reads one meanwhile.
// - At conversion end result loads, run clears and done flag sets together.
// - Power bit one runs the converter; zero shuts it off.
// - Control bit 1 reads zero; all other control bits reset to zero.
// - Each conversion yields a ten-bit value by successive approximation.
// - A conversion takes at least twelve bit periods.
// - Two bit periods pass after a conversion with hold capacitor disconnected.
// - The RC bit period is typically 4 us, between 2 and 6 us.
// - Conversions continue during sleep when the RC clock is selected.
// - Port reads return zero on every analog-configured pin.
// - An analog pin driven as output converts its own driven level.
// - Three-bit channel field selects among eight inputs, five on small packages.
// - Clearing run mid-conversion aborts and keeps the previous result.
// - Result is left or right justified in sixteen bits, zero filled.
// - With RC clock, start waits one instruction cycle first.
// - Sleep with a non-RC clock aborts and powers down; power bit stays.
module sarseq_top
	import sarseq_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int CHANNELS = 8
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_mode,
	input wire logic rc_osc,
	input wire logic cmp_above,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [2:0] channel_select,
	output logic hold_connect,
	output logic analog_on,
	output logic [9:0] dac_code,
	output logic conversion_done_flag
);
	// ==========================================
	// Register bus.
	logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [7:0] aw_idx_r, wdata_r;
	logic wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] ctrl_r, cfg_r, res_hi_r, res_lo_r, port_lat_r, dir_r, amask_r;
	logic done_r;

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == IDX_CONTROL) || (idx == IDX_ANALOG_CFG) ||
			(idx == IDX_RESULT_HIGH) || (idx == IDX_RESULT_LOW) ||
			(idx == IDX_PORT_DATA) || (idx == IDX_PIN_DIR) ||
			(idx == IDX_ANALOG_MASK) || (idx == IDX_STATUS);
	endfunction

	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire do_write = aw_held_r && w_held_r && !bvalid_r;
	wire wr_ok = do_write && is_mapped(aw_idx_r) && wstrb_r;
	wire wr_ctrl = wr_ok && (aw_idx_r == IDX_CONTROL);
	wire wr_res = wr_ok && ((aw_idx_r == IDX_RESULT_HIGH) || (aw_idx_r == IDX_RESULT_LOW));
	wire wr_stat = wr_ok && (aw_idx_r == IDX_STATUS);
	wire [7:0] ar_idx = s_axi_araddr[9:2];

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ==========================================
	// Pin inputs pass three flops; a level counts once stages two and three agree.
	logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_val_r;
	logic rc_s1_r, rc_s2_r, rc_s3_r, rc_val_r;
	wire rc_edge = (rc_s2_r == rc_s3_r) && rc_s3_r && !rc_val_r;

	wire [7:0] port_read = pin_val_r & ~amask_r;
	logic [7:0] rd_mux;
	always_comb
	begin
		case (ar_idx)
			IDX_CONTROL: rd_mux = ctrl_r;
			IDX_ANALOG_CFG: rd_mux = cfg_r;
			IDX_RESULT_HIGH: rd_mux = res_hi_r;
			IDX_RESULT_LOW: rd_mux = res_lo_r;
			IDX_PORT_DATA: rd_mux = port_read;
			IDX_PIN_DIR: rd_mux = dir_r;
			IDX_ANALOG_MASK: rd_mux = amask_r;
			IDX_STATUS: rd_mux = {7'h00, done_r};
			default: rd_mux = 8'h00;
		endcase
	end

	// ==========================================
	// Bit-period generation and sequencer.
	sarseq_state_type state_r, state_nxt;
	logic [4:0] div_cnt_r;
	logic [2:0] tcy_cnt_r;
	logic [3:0] bit_idx_r;
	logic [1:0] post_cnt_r;
	logic [9:0] sar_r;
	logic analog_on_r;
	logic [3:0] tad_seen_r;

	wire [1:0] clk_sel = ctrl_r[CTL_CLK_LO +: 2];
	wire power = ctrl_r[CTL_POWER];
	wire run = ctrl_r[CTL_RUN];
	wire rc_sel = (clk_sel == CLK_RC);
	wire [4:0] div_last = (clk_sel == CLK_DIV2) ? DIV2_LAST :
		(clk_sel == CLK_DIV8) ? DIV8_LAST : DIV32_LAST;
	wire div_tick = (div_cnt_r == div_last);
	// The RC period comes from outside, so its 2 to 6 us spread sets the bit period.
	wire tad_tick = rc_sel ? rc_edge : div_tick;
	wire tcy_done = (tcy_cnt_r == TCY_CLKS);
	// Only a non-RC clock is stopped by sleep; the RC source keeps converting.
	wire kill = sleep_mode && !rc_sel && power;
	wire converting = (state_r == ST_START) || (state_r == ST_SETUP) || (state_r == ST_BITS);
	wire abort = converting && (!run || kill || !power);
	// Losing power skips the post wait, since the converter is already off.
	sarseq_state_type abort_to;
	assign abort_to = power ? ST_POST : ST_IDLE;
	wire conv_end = (state_r == ST_BITS) && tad_tick && (bit_idx_r == 4'h0) && !abort;
	wire [9:0] sar_final = {sar_r[9:1], cmp_above};
	wire [15:0] end_pair = cfg_r[CFG_JUSTIFY] ? {6'h00, sar_final} : {sar_final, 6'h00};

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (power && run && !kill)
					state_nxt = ST_START;
			ST_START:
				if (abort)
					state_nxt = abort_to;
				else if (tcy_done && tad_tick)
					state_nxt = ST_SETUP;
			ST_SETUP:
				if (abort)
					state_nxt = abort_to;
				else if (tad_tick)
					state_nxt = ST_BITS;
			ST_BITS:
				if (abort)
					state_nxt = abort_to;
				else if (conv_end)
					state_nxt = ST_POST;
			ST_POST:
				if (!power || kill || (tad_tick && post_cnt_r == POST_TADS - 2'h1))
					state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Software may set run only while powered; hardware clearing wins at conversion end.
	logic [7:0] ctrl_nxt;
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
		begin
			ctrl_nxt = wdata_r;
			ctrl_nxt[CTL_RUN] = wdata_r[CTL_RUN] && power;
		end
		if (conv_end || kill || !power)
			ctrl_nxt[CTL_RUN] = 1'b0;
		ctrl_nxt[CTL_RESV] = 1'b0;
	end

	assign pin_out = port_lat_r;
	// A pin that drives keeps feeding its own level into the analog mux.
	assign pin_oe = ~dir_r;
	assign channel_select = ctrl_r[CTL_CHS_LO +: 3];
	assign hold_connect = analog_on_r && (state_r == ST_IDLE);
	assign analog_on = analog_on_r;
	assign dac_code = sar_r;
	assign conversion_done_flag = done_r;

	// ==========================================
	// Clocked state.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 8'h00;
			wdata_r <= 8'h00;
			wstrb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (aw_hs)
			begin
				aw_held_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[9:2];
			end
			if (w_hs)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[7:0];
				wstrb_r <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
			if (ar_hs)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= {24'h00_0000, rd_mux};
				rresp_r <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_r && s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r <= CONTROL_RST;
			cfg_r <= ANALOG_CFG_RST;
			res_hi_r <= 8'h00;
			res_lo_r <= 8'h00;
			port_lat_r <= 8'h00;
			dir_r <= PIN_DIR_RST;
			amask_r <= ANALOG_MASK_RST;
			done_r <= 1'b0;
		end
		else if (clk_en)
		begin
			ctrl_r <= ctrl_nxt;
			if (wr_ok && aw_idx_r == IDX_ANALOG_CFG)
				cfg_r <= wdata_r & CFG_WMASK;
			if (wr_ok && aw_idx_r == IDX_PORT_DATA)
				port_lat_r <= wdata_r;
			if (wr_ok && aw_idx_r == IDX_PIN_DIR)
				dir_r <= wdata_r;
			if (wr_ok && aw_idx_r == IDX_ANALOG_MASK)
				amask_r <= wdata_r;
			// The result pair moves on a finished conversion or a software write, never on an abort.
			if (conv_end)
			begin
				res_hi_r <= end_pair[15:8];
				res_lo_r <= end_pair[7:0];
			end
			else if (wr_res && aw_idx_r == IDX_RESULT_HIGH)
				res_hi_r <= wdata_r;
			else if (wr_res)
				res_lo_r <= wdata_r;
			// A completion in the same cycle as a software clear keeps the flag set.
			if (conv_end)
				done_r <= 1'b1;
			else if (wr_stat)
				done_r <= wdata_r[STAT_DONE];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
			pin_s3_r <= 8'h00;
			pin_val_r <= 8'h00;
			rc_s1_r <= 1'b0;
			rc_s2_r <= 1'b0;
			rc_s3_r <= 1'b0;
			rc_val_r <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_val_r <= (pin_val_r & (pin_s2_r ^ pin_s3_r)) | (pin_s3_r & ~(pin_s2_r ^ pin_s3_r));
			rc_s1_r <= rc_osc;
			rc_s2_r <= rc_s1_r;
			rc_s3_r <= rc_s2_r;
			if (rc_s2_r == rc_s3_r)
				rc_val_r <= rc_s3_r;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			div_cnt_r <= 5'h00;
			tcy_cnt_r <= 3'h0;
			bit_idx_r <= 4'h0;
			post_cnt_r <= 2'h0;
			sar_r <= 10'h000;
			analog_on_r <= 1'b0;
			tad_seen_r <= 4'h0;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			analog_on_r <= power && !kill;
			div_cnt_r <= (state_r == ST_IDLE || div_tick) ? 5'h00 : div_cnt_r + 5'h01;
			tcy_cnt_r <= (state_r != ST_START) ? 3'h0 : (tcy_done ? tcy_cnt_r : tcy_cnt_r + 3'h1);
			post_cnt_r <= (state_r != ST_POST) ? 2'h0 : (tad_tick ? post_cnt_r + 2'h1 : post_cnt_r);
			// Ticks seen while the start wait still runs are not bit periods.
			tad_seen_r <= (state_r == ST_IDLE || (state_r == ST_START && !tcy_done)) ? 4'h0 :
				(tad_tick ? tad_seen_r + 4'h1 : tad_seen_r);
			if (state_r == ST_SETUP && tad_tick)
			begin
				sar_r <= SAR_FIRST;
				bit_idx_r <= RESULT_MSB;
			end
			else if (state_r == ST_BITS && tad_tick)
			begin
				sar_r[bit_idx_r] <= cmp_above;
				if (bit_idx_r != 4'h0)
				begin
					sar_r[bit_idx_r - 4'h1] <= 1'b1;
					bit_idx_r <= bit_idx_r - 4'h1;
				end
			end
		end
	end

	// ==========================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence rc_start_s;
		(state_r == ST_IDLE) ##1 (state_r == ST_START && rc_sel && clk_en);
	endsequence
	a_end_loads_all: assert property ((conv_end && clk_en) |=> (!run && done_r &&
		{res_hi_r, res_lo_r} == $past(end_pair)))
		else $error("completion did not load result, clear run and set flag together");
	a_abort_keeps_result: assert property ((abort && clk_en && !wr_res) |=>
		$stable(res_hi_r) && $stable(res_lo_r) && state_r == ($past(power) ? ST_POST : ST_IDLE))
		else $error("abort changed the result pair");
	a_ctrl_bit_zero: assert property (ctrl_r[CTL_RESV] == 1'b0)
		else $error("control bit 1 is not zero");
	a_hold_open_busy: assert property ((state_r != ST_IDLE) |-> !hold_connect)
		else $error("hold capacitor connected while converting or waiting");
	a_twelve_tads: assert property (conv_end |-> tad_seen_r == TOTAL_TADS - 4'h1)
		else $error("conversion did not span twelve bit periods");
	a_power_off_idle: assert property ((!power && clk_en) |=>
		(state_r == ST_IDLE && !analog_on_r))
		else $error("converter active while power bit clear");
	a_sleep_abort_off: assert property ((kill && clk_en && !wr_ctrl) |=>
		(!analog_on_r && power && !run))
		else $error("sleep with core clock did not abort and power down");
	a_rc_wait_tcy: assert property (rc_start_s |-> (state_r == ST_START)[*4])
		else $error("RC start did not wait one instruction cycle");
	a_msb_first: assert property ((state_r == ST_SETUP && tad_tick && clk_en && !abort)
		|=> (sar_r == SAR_FIRST && bit_idx_r == RESULT_MSB))
		else $error("successive approximation did not begin at the top bit");
	a_port_analog_zero: assert property ((ar_hs && ar_idx == IDX_PORT_DATA && clk_en)
		|=> (s_axi_rdata[7:0] & $past(amask_r)) == 8'h00)
		else $error("analog pin read back as one");
endmodule
`default_nettype wire

// [testbench/sarseq_analog.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Analog pins and hold capacitor seen by the converter.
module sarseq_analog
(
	input wire logic clk,
	input wire logic [2:0] channel_select,
	input wire logic hold_connect,
	input wire logic [9:0] dac_code,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [9:0] ext_level,
	input wire logic [7:0] pad_level,
	output logic cmp_above,
	output logic [7:0] pin_in
);
	logic [9:0] held_r;
	logic [9:0] src;
	// A pin that drives itself presents its own rail level.
	assign src = pin_oe[channel_select] ? {10{pin_out[channel_select]}} : ext_level;
	// The capacitor keeps its charge while disconnected, so a late sample cannot leak in.
	always_ff @(posedge clk)
		if (hold_connect)
			held_r <= src;
	assign cmp_above = held_r >= dac_code;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad_level);
endmodule
`default_nettype wire

// [testbench/test_sar_adc_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_sequencer;
	import sarseq_pkg::*;
	typedef struct {string n; logic [31:0] e; logic [31:0] m; logic [1:0] r;} sarseq_exp_type;
	sarseq_exp_type rq[$];
	sarseq_exp_type wq[$];
	sarseq_exp_type x;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic sleep_mode = 1'b0;
	logic rc_osc = 1'b0;
	logic rc_on = 1'b0;
	logic [9:0] lvl = 10'h000;
	logic [7:0] pad = 8'h00;
	logic [15:0] rnd = 16'h0756;
	logic jr = 1'b0;
	logic [15:0] last = 16'h0000;
	int err_total = 0;
	int cmp_count = 0;
	wire logic awready, wready, bvalid, arready, rvalid, cmp_above, hold_connect, analog_on;
	wire logic conversion_done_flag;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] pin_in, pin_out, pin_oe;
	wire logic [2:0] channel_select;
	wire logic [9:0] dac_code;
	always #12.5 clk = ~clk;
	// The oscillator is much faster than real, to keep the run short.
	always
	begin
		#200;
		if (rc_on)
			rc_osc = ~rc_osc;
	end
	sarseq_top sarseq_top_i (.clk(clk), .rstn(rstn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.sleep_mode(sleep_mode), .rc_osc(rc_osc), .cmp_above(cmp_above), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .channel_select(channel_select),
		.hold_connect(hold_connect), .analog_on(analog_on), .dac_code(dac_code),
		.conversion_done_flag(conversion_done_flag));
	sarseq_analog sarseq_analog_i (.clk(clk), .channel_select(channel_select),
		.hold_connect(hold_connect), .dac_code(dac_code), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_level(lvl), .pad_level(pad), .cmp_above(cmp_above), .pin_in(pin_in));
	// ==========================================
	// Checking.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		begin
			cmp_count++;
			if (g !== e)
			begin
				err_total++;
				$display("FAIL %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	always @(posedge clk)
	begin
		if (rvalid === 1'b1)
		begin
			x = rq.pop_front();
			chk(x.n, x.e, rdata & x.m);
			chk("rresp", {30'h0, x.r}, {30'h0, rresp});
		end
		if (bvalid === 1'b1)
		begin
			x = wq.pop_front();
			chk("bresp", {30'h0, x.r}, {30'h0, bresp});
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] just(input logic [9:0] v, input logic j);
		return j ? {6'h00, v} : {v, 6'h00};
	endfunction
	// ==========================================
	// Bus cycles.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
		begin
			wq.push_back('{"bresp", 32'h0, 32'h0, r});
			awaddr <= {2'h0, idx, 2'h0};
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			forever
			begin
				@(posedge clk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (bvalid)
					break;
			end
		end
	endtask
	task automatic rd(input string n, input logic [7:0] idx, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] r);
		begin
			rq.push_back('{n, e, m, r});
			araddr <= {2'h0, idx, 2'h0};
			arvalid <= 1'b1;
			forever
			begin
				@(posedge clk);
				if (arready)
					arvalid <= 1'b0;
				if (rvalid)
					break;
			end
		end
	endtask
	task automatic res(input logic [15:0] v);
		begin
			rd("result high", IDX_RESULT_HIGH, {24'h0, v[15:8]}, 32'hff, RESP_OKAY);
			rd("result low", IDX_RESULT_LOW, {24'h0, v[7:0]}, 32'hff, RESP_OKAY);
		end
	endtask
	// Analog accuracy is not modelled, so every divider code is used at this core rate.
	task automatic conv(input logic [1:0] c, input logic [2:0] ch, input int dv, input logic [9:0] e);
		int n;
		begin
			wr(IDX_STATUS, 8'h00, RESP_OKAY);
			wr(IDX_CONTROL, {c, ch, 3'h1}, RESP_OKAY);
			repeat (20) @(posedge clk);
			rc_on <= (c == CLK_RC);
			wr(IDX_CONTROL, {c, ch, 3'h5}, RESP_OKAY);
			sleep_mode <= (c == CLK_RC);
			n = 0;
			while (conversion_done_flag !== 1'b1)
			begin
				@(posedge clk);
				n++;
			end
			if (dv > 0)
				chk("conv time", 32'h1, {31'h0, n >= 12 * dv && n <= 13 * dv + 8});
			n = 0;
			while (hold_connect !== 1'b1)
			begin
				@(posedge clk);
				n++;
			end
			if (dv > 0)
				chk("post wait", 32'h1, {31'h0, n >= 2 * dv - 1 && n <= 2 * dv + 2});
			sleep_mode <= 1'b0;
			rc_on <= 1'b0;
			rd("control", IDX_CONTROL, {24'h0, c, ch, 3'h1}, 32'hff, RESP_OKAY);
			rd("done flag", IDX_STATUS, 32'h1, 32'h1, RESP_OKAY);
			last = just(e, jr);
			res(last);
			$display("conversion code %0d finished", c);
		end
	endtask
	task automatic test_done;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, err_total);
			if (err_total == 0 && cmp_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done;
	end
	// ==========================================
	// Scenarios.
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd("control", IDX_CONTROL, {24'h0, CONTROL_RST}, 32'hff, RESP_OKAY);
		rd("pin dir", IDX_PIN_DIR, {24'h0, PIN_DIR_RST}, 32'hff, RESP_OKAY);
		rd("mask", IDX_ANALOG_MASK, {24'h0, ANALOG_MASK_RST}, 32'hff, RESP_OKAY);
		rd("status", IDX_STATUS, 32'h0, 32'hff, RESP_OKAY);
		wr(IDX_CONTROL, 8'hff, RESP_OKAY);
		rd("control", IDX_CONTROL, 32'hf9, 32'hff, RESP_OKAY);
		chk("analog on", 32'h1, {31'h0, analog_on});
		wr(IDX_CONTROL, 8'h00, RESP_OKAY);
		@(posedge clk);
		chk("analog on", 32'h0, {31'h0, analog_on});
		wstrb <= 4'h0;
		wr(IDX_CONTROL, 8'h01, RESP_OKAY);
		wstrb <= 4'hf;
		rd("control", IDX_CONTROL, 32'h0, 32'hff, RESP_OKAY);
		wr(8'h40, 8'h55, RESP_SLVERR);
		rd("unmapped", 8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
		$display("register test finished");
		for (int c = 0; c < 3; c++)
		begin
			jr = c[0];
			wr(IDX_ANALOG_CFG, {jr, 7'h00}, RESP_OKAY);
			lvl <= rnd[9:0];
			conv(c[1:0], 3'h7 - 3'(2 * c), 2 << (2 * c), rnd[9:0]);
			rnd = lfsr(rnd);
		end
		wr(IDX_PIN_DIR, 8'hfe, RESP_OKAY);
		wr(IDX_PORT_DATA, 8'h01, RESP_OKAY);
		conv(CLK_DIV8, 3'h0, 8, 10'h3ff);
		wr(IDX_PIN_DIR, 8'hff, RESP_OKAY);
		conv(CLK_RC, 3'h2, 0, lvl);
		wr(IDX_ANALOG_MASK, 8'h0f, RESP_OKAY);
		pad <= rnd[7:0];
		repeat (5) @(posedge clk);
		rd("port", IDX_PORT_DATA, {24'h0, rnd[7:0] & 8'hf0}, 32'hff, RESP_OKAY);
		pad <= 8'h00;
		repeat (5) @(posedge clk);
		rd("port", IDX_PORT_DATA, 32'h0, 32'hff, RESP_OKAY);
		lvl <= ~lvl;
		wr(IDX_STATUS, 8'h00, RESP_OKAY);
		wr(IDX_CONTROL, {CLK_DIV32, 3'h1, 3'h5}, RESP_OKAY);
		repeat (100) @(posedge clk);
		wr(IDX_CONTROL, {CLK_DIV32, 3'h1, 3'h1}, RESP_OKAY);
		repeat (200) @(posedge clk);
		chk("done flag", 32'h0, {31'h0, conversion_done_flag});
		res(last);
		$display("abort test finished");
		wr(IDX_CONTROL, {CLK_DIV8, 3'h3, 3'h5}, RESP_OKAY);
		repeat (30) @(posedge clk);
		sleep_mode <= 1'b1;
		repeat (2) @(posedge clk);
		chk("analog on", 32'h0, {31'h0, analog_on});
		rd("power bit", IDX_CONTROL, 32'h1, 32'h1, RESP_OKAY);
		sleep_mode <= 1'b0;
		repeat (40) @(posedge clk);
		res(last);
		$display("sleep test finished");
		wr(IDX_CONTROL, {CLK_DIV8, 3'h3, 3'h5}, RESP_OKAY);
		repeat (30) @(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("analog on", 32'h0, {31'h0, analog_on});
		rd("control", IDX_CONTROL, 32'h0, 32'hff, RESP_OKAY);
		$display("reset test finished");
		test_done;
	end
endmodule
`default_nettype wire
